// [inc/snv_pkg.sv]
// Package of constants and types for the serial nvSRAM command and status block.
`default_nettype none
package snv_pkg;
  // -----------------------------------------------------------------
  // Opcodes
  // -----------------------------------------------------------------
  localparam logic [7:0] STATUS_READ_OP = 8'h05;
  localparam logic [7:0] STATUS_READ_FAST_OP = 8'h09;
  localparam logic [7:0] STATUS_WRITE_OP = 8'h01;
  localparam logic [7:0] WRITE_LATCH_SET_OP = 8'h06;
  localparam logic [7:0] WRITE_LATCH_CLEAR_OP = 8'h04;
  localparam logic [7:0] ARRAY_READ_OP = 8'h03;
  localparam logic [7:0] ARRAY_READ_FAST_OP = 8'h0b;
  localparam logic [7:0] ARRAY_WRITE_OP = 8'h02;
  localparam logic [7:0] SAVE_OP = 8'h3c;
  localparam logic [7:0] RESTORE_OP = 8'h60;
  localparam logic [7:0] AUTO_SAVE_ON_OP = 8'h59;
  localparam logic [7:0] AUTO_SAVE_OFF_OP = 8'h19;
  localparam logic [7:0] SLEEP_OP = 8'hb9;
  localparam logic [7:0] SERIAL_NUM_WRITE_OP = 8'hc2;
  localparam logic [7:0] SERIAL_NUM_READ_OP = 8'hc3;
  localparam logic [7:0] SERIAL_NUM_READ_FAST_OP = 8'hc9;
  localparam logic [7:0] IDENT_READ_OP = 8'h9f;
  localparam logic [7:0] IDENT_READ_FAST_OP = 8'h99;
  localparam logic [7:0] RESERVED_OP = 8'h1e;
  // -----------------------------------------------------------------
  // Status byte fields
  // -----------------------------------------------------------------
  localparam int HW_GUARD_ENABLE_BIT = 7;
  localparam int SERIAL_NUM_LOCK_BIT = 6;
  localparam int BLOCK_GUARD_HI_BIT = 3;
  localparam int BLOCK_GUARD_LO_BIT = 2;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'hcc;
  localparam logic [7:0] STATUS_SHIP_VALUE = 8'h00;
  // -----------------------------------------------------------------
  // Block guard address limits
  // -----------------------------------------------------------------
  localparam logic [14:0] GUARD_QUARTER_BASE = 15'h6000;
  localparam logic [14:0] GUARD_HALF_BASE = 15'h4000;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWERUP_RESTORE_TIME_US = 20000;
  localparam int POWERUP_RESTORE_CYCLES = POWERUP_RESTORE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERDOWN_WRITE_GRACE_NS = 25000;
  localparam int POWERDOWN_WRITE_GRACE_CYCLES = POWERDOWN_WRITE_GRACE_NS / CLK_PERIOD_NS;
  localparam int STANDBY_ENTRY_DELAY_NS = 100000;
  localparam int STANDBY_ENTRY_DELAY_CYCLES = STANDBY_ENTRY_DELAY_NS / CLK_PERIOD_NS;
  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    SNV_OFF, SNV_RESTORE, SNV_WAIT_EDGE, SNV_IDLE, SNV_OPCODE, SNV_DATA, SNV_IGNORE, SNV_DOWN
  } snv_phase_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic valid;
  } snv_word_s;
endpackage
`default_nettype wire

// [logic/snv_cmd_status.sv]
// Serial nvSRAM instruction decoder, status byte and power gating.
`timescale 1ns/10ps
`default_nettype none
module snv_cmd_status #(
  parameter int RESTORE_CYCLES = snv_pkg::POWERUP_RESTORE_CYCLES,
  parameter int STANDBY_CYCLES = snv_pkg::STANDBY_ENTRY_DELAY_CYCLES,
  parameter int GRACE_CYCLES = snv_pkg::POWERDOWN_WRITE_GRACE_CYCLES,
  parameter int SAVE_CYCLES = 64,
  parameter int SW_RESTORE_CYCLES = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Supply monitor
  input wire logic supply_ok,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic protect_n,
  // Array side
  input wire logic [14:0] array_addr,
  input wire logic array_write_done,
  output logic array_write_allowed,
  output logic access_allowed,
  // Decoded instruction stream
  output snv_pkg::snv_word_s cmd_word,
  input wire logic cmd_ready,
  // Mode status
  output logic standby,
  output logic auto_save_on,
  output logic save_busy
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  localparam int CW = 32;
  typedef struct packed {
    logic [1:0] cs_sy;
    logic [1:0] sck_sy;
    logic [1:0] si_sy;
    logic [1:0] wp_sy;
    logic [1:0] pw_sy;
    logic cs_d1;
    logic sck_d1;
    logic mode3_arm;
    snv_pkg::snv_phase_e phase;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] opcode;
    logic [7:0] nv_status;
    logic [7:0] status_live;
    logic write_latch;
    logic auto_save;
    logic dirty;
    logic [CW-1:0] busy_cnt;
    logic [CW-1:0] sb_cnt;
    logic [7:0] out_sr;
    logic so;
    logic so_oe;
    logic stby;
    logic wr_seen;
    logic [1:0] buf_cnt;
    snv_pkg::snv_word_s buf0;
    snv_pkg::snv_word_s buf1;
  } snv_state_s;
  snv_state_s s_q, s_d;

  function automatic logic latch_needed(input logic [7:0] op);
    latch_needed = op inside {snv_pkg::STATUS_WRITE_OP, snv_pkg::ARRAY_WRITE_OP, snv_pkg::SERIAL_NUM_WRITE_OP,
      snv_pkg::SAVE_OP, snv_pkg::RESTORE_OP, snv_pkg::AUTO_SAVE_ON_OP, snv_pkg::AUTO_SAVE_OFF_OP};
  endfunction

  function automatic logic op_known(input logic [7:0] op);
    op_known = op inside {snv_pkg::STATUS_READ_OP, snv_pkg::STATUS_READ_FAST_OP, snv_pkg::STATUS_WRITE_OP,
      snv_pkg::WRITE_LATCH_SET_OP, snv_pkg::WRITE_LATCH_CLEAR_OP, snv_pkg::ARRAY_READ_OP,
      snv_pkg::ARRAY_READ_FAST_OP, snv_pkg::ARRAY_WRITE_OP, snv_pkg::SAVE_OP, snv_pkg::RESTORE_OP,
      snv_pkg::AUTO_SAVE_ON_OP, snv_pkg::AUTO_SAVE_OFF_OP, snv_pkg::SLEEP_OP, snv_pkg::SERIAL_NUM_WRITE_OP,
      snv_pkg::SERIAL_NUM_READ_OP, snv_pkg::SERIAL_NUM_READ_FAST_OP, snv_pkg::IDENT_READ_OP,
      snv_pkg::IDENT_READ_FAST_OP};
  endfunction

  logic cs_fall, cs_rise, sck_rise, sck_fall, cs_low, wp_active, status_locked;
  logic [7:0] status_view, rx_byte;
  logic pop;

  assign cs_low = !s_q.cs_sy[1];
  assign cs_fall = s_q.cs_d1 && !s_q.cs_sy[1];
  assign cs_rise = !s_q.cs_d1 && s_q.cs_sy[1];
  assign sck_rise = !s_q.sck_d1 && s_q.sck_sy[1] && cs_low && !s_q.mode3_arm;
  assign sck_fall = s_q.sck_d1 && !s_q.sck_sy[1] && cs_low;
  assign wp_active = s_q.status_live[snv_pkg::HW_GUARD_ENABLE_BIT] && !s_q.wp_sy[1];
  assign status_locked = wp_active;
  assign status_view = {s_q.status_live[7:6], 2'b00, s_q.status_live[3:2], s_q.write_latch,
    (s_q.busy_cnt != '0)};
  assign rx_byte = {s_q.shift[6:0], s_q.si_sy[1]};
  assign pop = s_q.buf0.valid && cmd_ready;

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cs_sy = {s_q.cs_sy[0], spi_cs_n};
    s_d.sck_sy = {s_q.sck_sy[0], spi_sck};
    s_d.si_sy = {s_q.si_sy[0], spi_si};
    s_d.wp_sy = {s_q.wp_sy[0], protect_n};
    s_d.pw_sy = {s_q.pw_sy[0], supply_ok};
    s_d.cs_d1 = s_q.cs_sy[1];
    s_d.sck_d1 = s_q.sck_sy[1];
    s_d.wr_seen = 1'b0;
    if (s_q.busy_cnt != '0) begin
      s_d.busy_cnt = s_q.busy_cnt - 1'b1;
    end
    if (pop) begin
      s_d.buf0 = s_q.buf1;
      s_d.buf1 = '0;
      s_d.buf_cnt = s_q.buf_cnt - 2'd1;
    end
    // Standby entry counts from deselect and waits for any save or restore.
    // A running cycle holds the standby flag as it is, so power-up stays in standby.
    if (cs_low) begin
      s_d.sb_cnt = CW'(STANDBY_CYCLES);
      s_d.stby = 1'b0;
    end else if (s_q.busy_cnt != '0) begin
      s_d.sb_cnt = CW'(STANDBY_CYCLES);
    end else if (s_q.sb_cnt != '0) begin
      s_d.sb_cnt = s_q.sb_cnt - 1'b1;
    end else begin
      s_d.stby = 1'b1;
    end
    if (cs_rise || !cs_low) begin
      s_d.so_oe = 1'b0;
      s_d.so = 1'b0;
    end
    case (s_q.phase)
      snv_pkg::SNV_OFF: begin
        s_d.so_oe = 1'b0;
        if (s_q.pw_sy[1]) begin
          s_d.phase = snv_pkg::SNV_RESTORE;
          s_d.busy_cnt = CW'(RESTORE_CYCLES);
          s_d.status_live = s_q.nv_status;
          s_d.write_latch = 1'b0;
          s_d.dirty = 1'b0;
          s_d.stby = 1'b1;
        end
      end
      snv_pkg::SNV_RESTORE: begin
        if (s_q.busy_cnt == CW'(1) || s_q.busy_cnt == '0) begin
          s_d.busy_cnt = '0;
          s_d.phase = snv_pkg::SNV_WAIT_EDGE;
        end
      end
      snv_pkg::SNV_WAIT_EDGE, snv_pkg::SNV_IDLE: begin
        if (cs_fall) begin
          s_d.phase = snv_pkg::SNV_OPCODE;
          s_d.bitcnt = 3'd0;
          s_d.bytecnt = 2'd0;
          s_d.mode3_arm = s_q.sck_sy[1];
        end
      end
      snv_pkg::SNV_OPCODE, snv_pkg::SNV_DATA: begin
        if (s_q.mode3_arm && !s_q.sck_sy[1]) begin
          s_d.mode3_arm = 1'b0;
        end
        if (sck_rise) begin
          s_d.shift = rx_byte;
          s_d.bitcnt = s_q.bitcnt + 3'd1;
        end
        if (sck_rise && s_q.bitcnt == 3'd7) begin
          if (s_q.phase == snv_pkg::SNV_OPCODE) begin
            s_d.opcode = rx_byte;
            s_d.phase = snv_pkg::SNV_DATA;
            if (!op_known(rx_byte) || (latch_needed(rx_byte) && !s_q.write_latch) ||
                s_q.busy_cnt != '0) begin
              s_d.phase = snv_pkg::SNV_IGNORE;
            end else begin
              case (rx_byte)
                snv_pkg::STATUS_READ_OP: s_d.out_sr = status_view;
                snv_pkg::SAVE_OP: begin
                  s_d.busy_cnt = CW'(SAVE_CYCLES);
                  s_d.nv_status = s_q.status_live;
                  s_d.dirty = 1'b0;
                end
                snv_pkg::RESTORE_OP: begin
                  s_d.busy_cnt = CW'(SW_RESTORE_CYCLES);
                  s_d.status_live = s_q.nv_status;
                  s_d.dirty = 1'b0;
                end
                snv_pkg::AUTO_SAVE_ON_OP: s_d.auto_save = 1'b1;
                snv_pkg::AUTO_SAVE_OFF_OP: s_d.auto_save = 1'b0;
                default: s_d.out_sr = 8'h00;
              endcase
              if (rx_byte inside {snv_pkg::SAVE_OP, snv_pkg::RESTORE_OP, snv_pkg::AUTO_SAVE_ON_OP,
                  snv_pkg::AUTO_SAVE_OFF_OP}) begin
                s_d.write_latch = 1'b0;
              end
              s_d.wr_seen = s_q.buf_cnt != 2'd2 || pop;
            end
          end else begin
            s_d.bytecnt = (s_q.bytecnt == 2'd3) ? 2'd3 : s_q.bytecnt + 2'd1;
            if (s_q.opcode == snv_pkg::STATUS_READ_FAST_OP && s_q.bytecnt == 2'd0) begin
              s_d.out_sr = status_view;
            end
            if (s_q.opcode == snv_pkg::STATUS_READ_OP) begin
              s_d.out_sr = status_view;
            end
            if (s_q.opcode == snv_pkg::STATUS_WRITE_OP && s_q.bytecnt == 2'd0) begin
              if (!status_locked) begin
                s_d.status_live = (s_q.status_live & ~snv_pkg::STATUS_WRITE_MASK) |
                  (rx_byte & snv_pkg::STATUS_WRITE_MASK);
                if (s_q.status_live[snv_pkg::SERIAL_NUM_LOCK_BIT]) begin
                  s_d.status_live[snv_pkg::SERIAL_NUM_LOCK_BIT] = 1'b1;
                end
                s_d.dirty = 1'b1;
              end
              s_d.write_latch = 1'b0;
            end
            s_d.wr_seen = s_q.buf_cnt != 2'd2 || pop;
          end
        end
        if (s_q.phase == snv_pkg::SNV_DATA && sck_fall && (s_q.opcode == snv_pkg::STATUS_READ_OP ||
            (s_q.opcode == snv_pkg::STATUS_READ_FAST_OP && s_q.bytecnt != 2'd0))) begin
          s_d.so = s_q.out_sr[7];
          s_d.out_sr = {s_q.out_sr[6:0], s_q.out_sr[7]};
          s_d.so_oe = 1'b1;
        end
        if (cs_rise) begin
          if (s_q.opcode == snv_pkg::WRITE_LATCH_SET_OP && s_q.phase == snv_pkg::SNV_DATA) begin
            s_d.write_latch = 1'b1;
          end
          if (s_q.opcode == snv_pkg::WRITE_LATCH_CLEAR_OP && s_q.phase == snv_pkg::SNV_DATA) begin
            s_d.write_latch = 1'b0;
          end
          if (s_q.phase == snv_pkg::SNV_DATA && (s_q.opcode == snv_pkg::ARRAY_WRITE_OP ||
              s_q.opcode == snv_pkg::SERIAL_NUM_WRITE_OP)) begin
            s_d.write_latch = 1'b0;
          end
          s_d.phase = snv_pkg::SNV_IDLE;
        end
      end
      snv_pkg::SNV_IGNORE: begin
        s_d.so_oe = 1'b0;
        if (cs_rise) begin
          s_d.phase = snv_pkg::SNV_IDLE;
        end
      end
      snv_pkg::SNV_DOWN: begin
        s_d.so_oe = 1'b0;
        if (s_q.busy_cnt == '0) begin
          s_d.phase = snv_pkg::SNV_OFF;
        end
      end
      default: s_d.phase = snv_pkg::SNV_OFF;
    endcase
    if (array_write_done) begin
      s_d.dirty = 1'b1;
    end
    // A store of the array and status follows loss of supply only when power-loss save is on and the contents are dirty or a write just finished.
    if (!s_q.pw_sy[1] && s_q.phase != snv_pkg::SNV_OFF && s_q.phase != snv_pkg::SNV_DOWN) begin
      s_d.phase = snv_pkg::SNV_DOWN;
      s_d.so_oe = 1'b0;
      s_d.busy_cnt = CW'(GRACE_CYCLES);
      if (s_q.auto_save && (s_q.dirty || array_write_done)) begin
        s_d.nv_status = s_q.status_live;
        s_d.busy_cnt = CW'(GRACE_CYCLES + SAVE_CYCLES);
      end
    end
    if (s_d.wr_seen) begin
      if (s_q.buf_cnt - (pop ? 2'd1 : 2'd0) == 2'd0) begin
        s_d.buf0 = '{opcode: s_d.opcode, data: rx_byte, valid: 1'b1};
      end else begin
        s_d.buf1 = '{opcode: s_d.opcode, data: rx_byte, valid: 1'b1};
      end
      s_d.buf_cnt = s_q.buf_cnt - (pop ? 2'd1 : 2'd0) + 2'd1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{cs_sy: 2'b11, sck_sy: 2'b00, si_sy: 2'b00, wp_sy: 2'b11, pw_sy: 2'b00, cs_d1: 1'b1,
        phase: snv_pkg::SNV_OFF, nv_status: snv_pkg::STATUS_SHIP_VALUE, auto_save: 1'b1, stby: 1'b1,
        default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign spi_so = s_q.so;
  assign spi_so_oe = s_q.so_oe;
  assign cmd_word = s_q.buf0;
  assign standby = s_q.stby;
  assign auto_save_on = s_q.auto_save;
  assign save_busy = s_q.busy_cnt != '0;
  assign access_allowed = s_q.busy_cnt == '0 && (s_q.phase inside {snv_pkg::SNV_WAIT_EDGE,
    snv_pkg::SNV_IDLE, snv_pkg::SNV_OPCODE, snv_pkg::SNV_DATA, snv_pkg::SNV_IGNORE});
  always_comb begin
    case (s_q.status_live[3:2])
      2'b01: array_write_allowed = array_addr < snv_pkg::GUARD_QUARTER_BASE;
      2'b10: array_write_allowed = array_addr < snv_pkg::GUARD_HALF_BASE;
      2'b11: array_write_allowed = 1'b0;
      default: array_write_allowed = 1'b1;
    endcase
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_bits_zero: assert property (@(posedge mclk) disable iff (!reset_n) status_view[5:4] == 2'b00)
    else $error("unused status bits not zero");
  chk_lock_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(s_q.status_live[6]) && s_q.phase != snv_pkg::SNV_RESTORE |-> s_q.status_live[6])
    else $error("serial lock cleared");
  chk_no_drive_ignore: assert property (@(posedge mclk) disable iff (!reset_n)
    s_q.phase == snv_pkg::SNV_IGNORE |=> !spi_so_oe)
    else $error("output driven after bad opcode");
  chk_busy_bit: assert property (@(posedge mclk) disable iff (!reset_n) status_view[0] == save_busy)
    else $error("busy bit disagrees");
  chk_guard_all: assert property (@(posedge mclk) disable iff (!reset_n)
    s_q.status_live[3:2] == 2'b11 |-> !array_write_allowed)
    else $error("full guard not blocking");
  chk_off_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
    s_q.phase == snv_pkg::SNV_OFF |-> !access_allowed && !spi_so_oe)
    else $error("access while unpowered");
  chk_wp_refuse: assert property (@(posedge mclk) disable iff (!reset_n)
    status_locked && s_q.phase != snv_pkg::SNV_RESTORE |=> $stable(s_q.status_live))
    else $error("status written while guarded");
  chk_latch_ign: assert property (@(posedge mclk) disable iff (!reset_n)
    s_q.phase == snv_pkg::SNV_OPCODE && sck_rise && s_q.bitcnt == 3'd7 && latch_needed(rx_byte) &&
    !s_q.write_latch |=> s_q.phase == snv_pkg::SNV_IGNORE)
    else $error("write instruction not ignored");
endmodule // snv_cmd_status
`default_nettype wire

// [test/snv_spi_host.sv]
// Serial host model that frames instructions toward the command and status block.
`timescale 1ns/10ps
`default_nettype none
module snv_spi_host (
  // Serial pins
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si,
  input wire logic spi_so,
  input wire logic spi_so_oe
);
  logic oe_seen;
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
    oe_seen = 1'b0;
  end
  // -----------------------------------------------------------------
  // One selected frame; the byte seen on the return line during the last byte comes back.
  // -----------------------------------------------------------------
  task automatic frame(input logic [7:0] txq[$], output logic [7:0] last_rx);
    logic [7:0] r;
    r = 8'h00;
    #20 spi_cs_n = 1'b0;
    oe_seen = 1'b0;
    foreach (txq[i]) begin
      for (int b = 7; b >= 0; b--) begin
        spi_si = txq[i][b];
        #62.5 spi_sck = 1'b1;
        r = {r[6:0], (spi_so_oe ? spi_so : 1'bx)};
        oe_seen = oe_seen | spi_so_oe;
        #62.5 spi_sck = 1'b0;
      end
    end
    #40 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    last_rx = r;
    #200;
  endtask
endmodule // snv_spi_host
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the command and status block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic supply_ok = 1'b1;
  logic protect_n = 1'b1;
  logic array_write_done = 1'b0;
  logic cmd_ready = 1'b1;
  logic [14:0] array_addr = 15'h0000;
  wire logic spi_cs_n, spi_sck, spi_si;
  logic spi_so, spi_so_oe, array_write_allowed, access_allowed, standby, auto_save_on, save_busy;
  snv_pkg::snv_word_s cmd_word;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] v;
  logic [15:0] lo;
  int n;
  always #5 mclk = ~mclk;
  snv_cmd_status #(.RESTORE_CYCLES(20), .STANDBY_CYCLES(60), .GRACE_CYCLES(20), .SAVE_CYCLES(400),
    .SW_RESTORE_CYCLES(20)) DUT (.mclk(mclk), .reset_n(reset_n), .supply_ok(supply_ok),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .protect_n(protect_n), .array_addr(array_addr), .array_write_done(array_write_done),
    .array_write_allowed(array_write_allowed), .access_allowed(access_allowed), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .standby(standby), .auto_save_on(auto_save_on), .save_busy(save_busy));
  snv_spi_host host (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe));
  // -----------------------------------------------------------------
  // Shared checks and instruction helpers
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic rd_status(output logic [7:0] s);
    host.frame('{snv_pkg::STATUS_READ_OP, 8'h00}, s);
  endtask
  task automatic latched_op(input logic [7:0] op);
    host.frame('{snv_pkg::WRITE_LATCH_SET_OP}, v);
    host.frame('{op}, v);
  endtask
  task automatic wr_status(input logic [7:0] s);
    host.frame('{snv_pkg::WRITE_LATCH_SET_OP}, v);
    host.frame('{snv_pkg::STATUS_WRITE_OP, s}, v);
  endtask
  initial begin
    #900us;
    $display("unexpected timeout expected finish seen hang");
    mismatches++;
    end_of_test();
  end
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    tick(10);
    reset_n = 1'b1;
    for (n = 0; n < 100 && access_allowed !== 1'b1; n++) tick(1);
    chk("access after restore", 1, access_allowed);
    chk("standby after reset", 1, standby);
    rd_status(v);
    chk("status after reset", 8'h00, v);
    chk("standby while idle delay", 0, standby);
    for (n = 0; n < 80 && standby !== 1'b1; n++) tick(1);
    chk("standby after delay", 1, standby);
    host.frame('{snv_pkg::STATUS_WRITE_OP, 8'hff}, v);
    rd_status(v);
    chk("status write without latch", 8'h00, v);
    host.frame('{snv_pkg::WRITE_LATCH_SET_OP}, v);
    rd_status(v);
    chk("latch set", 8'h02, v);
    host.frame('{snv_pkg::WRITE_LATCH_CLEAR_OP}, v);
    rd_status(v);
    chk("latch clear", 8'h00, v);
    wr_status(8'hff);
    rd_status(v);
    chk("status write mask", 8'hcc, v);
    host.frame('{snv_pkg::STATUS_READ_FAST_OP, 8'h00, 8'h00}, v);
    chk("fast status read", 8'hcc, v);
    protect_n = 1'b0;
    wr_status(8'h00);
    rd_status(v);
    chk("guarded status write", 8'hcc, v);
    protect_n = 1'b1;
    for (int bp = 0; bp < 4; bp++) begin
      wr_status({4'h0, bp[1:0], 2'b00});
      rd_status(v);
      chk("guard and lock", {8'h40 | (bp[7:0] << 2)}, v);
      lo = (bp == 3) ? 16'h0000 : (bp == 2) ? 16'h4000 : (bp == 1) ? 16'h6000 : 16'h8000;
      for (int k = 0; k < 6; k++) begin
        array_addr = (k == 0) ? 15'h0000 : (k == 1) ? 15'h3fff : (k == 2) ? 15'h4000 :
          (k == 3) ? 15'h5fff : (k == 4) ? 15'h6000 : 15'h7fff;
        tick(1);
        chk("write allowed", {15'h0000, ({1'b0, array_addr} < lo)}, array_write_allowed);
      end
    end
    protect_n = 1'b0;
    wr_status(8'h00);
    rd_status(v);
    chk("pin ignored without enable", 8'h40, v);
    protect_n = 1'b1;
    host.frame('{snv_pkg::RESERVED_OP, 8'h00, 8'h00}, v);
    chk("output released on unknown code", 0, host.oe_seen);
    host.frame('{snv_pkg::SAVE_OP}, v);
    chk("save refused without latch", 0, save_busy);
    latched_op(snv_pkg::AUTO_SAVE_OFF_OP);
    chk("power-loss save off", 0, auto_save_on);
    latched_op(snv_pkg::AUTO_SAVE_ON_OP);
    chk("power-loss save on", 1, auto_save_on);
    latched_op(snv_pkg::SAVE_OP);
    chk("busy during save", 1, save_busy);
    chk("access during save", 0, access_allowed);
    for (n = 0; n < 500 && save_busy !== 1'b0; n++) tick(1);
    rd_status(v);
    chk("latch cleared after save", 8'h40, v);
    cmd_ready = 1'b0;
    host.frame('{snv_pkg::IDENT_READ_OP}, v);
    host.frame('{snv_pkg::WRITE_LATCH_SET_OP}, v);
    for (n = 0; n < 8 && cmd_word.valid === 1'b1; n++) begin
      cmd_ready = 1'b1;
      tick(1);
      cmd_ready = 1'b0;
      tick(1);
    end
    host.frame('{snv_pkg::ARRAY_WRITE_OP, 8'ha5, 8'h3c}, v);
    chk("buffer head", {snv_pkg::ARRAY_WRITE_OP, snv_pkg::ARRAY_WRITE_OP}, cmd_word[16:1]);
    cmd_ready = 1'b1;
    tick(1);
    cmd_ready = 1'b0;
    chk("buffer second", {snv_pkg::ARRAY_WRITE_OP, 8'ha5}, cmd_word[16:1]);
    cmd_ready = 1'b1;
    array_write_done = 1'b1;
    tick(1);
    array_write_done = 1'b0;
    chk("buffer drained", 0, cmd_word.valid);
    supply_ok = 1'b0;
    tick(10);
    chk("access after supply loss", 0, access_allowed);
    chk("save after supply loss", 1, save_busy);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
